/* File: rtl/bdm_pkg.sv */
// Purpose: Shared constants and carriers of the background debug block
// Assumes: 17-bit serial frames, 32-bit core addresses and data
// Notes: Operation word is opcode[15:12], size[7:6], index[3:0]
package bdm_pkg;
  localparam int FRAME_W = 17;
  localparam int OP_LSB = 12;
  localparam int SIZE_LSB = 6;
  localparam int IDX_LSB = 0;
  localparam int SYS_CORE_BIT = 3;
  localparam int RST_CYCLES = 512;

  localparam logic [3:0] OP_NOP = 4'h0;
  localparam logic [3:0] OP_CORE_RD = 4'h1;
  localparam logic [3:0] OP_CORE_WR = 4'h2;
  localparam logic [3:0] OP_SYS_RD = 4'h3;
  localparam logic [3:0] OP_SYS_WR = 4'h4;
  localparam logic [3:0] OP_MEM_RD = 4'h5;
  localparam logic [3:0] OP_MEM_WR = 4'h6;
  localparam logic [3:0] OP_DUMP = 4'h7;
  localparam logic [3:0] OP_FILL = 4'h8;
  localparam logic [3:0] OP_GO = 4'h9;
  localparam logic [3:0] OP_CALL = 4'hA;
  localparam logic [3:0] OP_RST = 4'hB;

  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;

  localparam logic [3:0] SYS_SCRATCH = 4'h0;
  localparam logic [3:0] SYS_FAULT = 4'h1;
  localparam logic [3:0] SYS_RFP = 4'h2;
  localparam logic [3:0] SYS_LIP = 4'h3;
  localparam logic [3:0] SYS_SRC = 4'h4;
  localparam logic [3:0] SYS_DST = 4'h5;
  localparam logic [3:0] SYS_SUPERVISOR_STATE_BIT = 4'h6;
  localparam logic [3:0] SP_IDX = 4'hF;

  localparam logic [16:0] RSP_OK = 17'h0FFFF;
  localparam logic [16:0] RSP_NOT_READY = 17'h10000;
  localparam logic [16:0] RSP_BERR = 17'h10001;
  localparam logic [16:0] RSP_ILLEGAL = 17'h1FFFF;

  localparam logic [15:0] DBL_FAULT_LOW = 16'hFFFF;
  localparam logic [31:0] ENTRY_BACKGROUND_INSTRUCTION = 32'h00000001;
  localparam logic [31:0] ENTRY_BREAKPOINT_IN = 32'h00000000;
  localparam logic [31:0] LIP_DBL_RESET = 32'h00000001;
  localparam logic [31:0] REG_RST = 32'h00000000;
  localparam logic [2:0] SPACE_RST = 3'h0;

  typedef struct packed {
    logic we;
    logic sys;
    logic [3:0] idx;
    logic [31:0] wdata;
  } creg_req_t;

  typedef struct packed {
    logic we;
    logic [2:0] space;
    logic [1:0] size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mem_req_t;
endpackage : bdm_pkg

/* File: rtl/serial_word_shifter.sv */
// Purpose: 17-bit full-duplex serial word engine on the debug link
// Assumes: clock and data already pass two flip-flops upstream
// Notes: Link clock edges are found by sampling at mclk
`timescale 1ns/1ps
`default_nettype none
module serial_word_shifter
  import bdm_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Link side, synchronised
  input wire logic enable,
  input wire logic sclk_s,
  input wire logic sdi_s,
  output logic sdo,
  // Word side
  input wire logic [16:0] tx_word,
  output logic [15:0] rx_word,
  output logic rx_valid
);
  logic prev_ff, nxt_prev;
  logic [4:0] cnt_ff, nxt_cnt;
  logic [16:0] in_ff, nxt_in;
  logic [16:0] out_ff, nxt_out;
  logic [15:0] rx_ff, nxt_rx;
  logic rxv_ff, nxt_rxv;

  always_comb begin
    nxt_prev = sclk_s;
    nxt_cnt = cnt_ff;
    nxt_in = in_ff;
    nxt_out = out_ff;
    nxt_rx = rx_ff;
    nxt_rxv = 1'h0;
    if (!enable) begin
      nxt_cnt = 5'h00;
      nxt_out = tx_word;
    end else if (sclk_s && !prev_ff) begin
      // Capture on the rising edge, MSB first
      nxt_in = {in_ff[15:0], sdi_s}; // RULE24 RULE23
      if (cnt_ff == 5'(FRAME_W - 1)) begin
        nxt_cnt = 5'h00;
        nxt_rx = {in_ff[14:0], sdi_s}; // RULE23
        nxt_rxv = 1'h1;
      end else begin
        nxt_cnt = cnt_ff + 5'h01;
      end
    end else if (!sclk_s && prev_ff && cnt_ff != 5'h00) begin
      nxt_out = {out_ff[15:0], 1'h0}; // RULE24
    end else if (cnt_ff == 5'h00) begin
      // Between frames the next answer is parked here
      nxt_out = tx_word; // RULE7
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      // Matches the idle-high link clock, so no false edge follows reset
      prev_ff <= 1'h1;
      cnt_ff <= 5'h00;
      in_ff <= 17'h00000;
      out_ff <= 17'h00000;
      rx_ff <= 16'h0000;
      rxv_ff <= 1'h0;
    end else begin
      prev_ff <= nxt_prev;
      cnt_ff <= nxt_cnt;
      in_ff <= nxt_in;
      out_ff <= nxt_out;
      rx_ff <= nxt_rx;
      rxv_ff <= nxt_rxv;
    end
  end

  assign sdo = out_ff[16];
  assign rx_word = rx_ff;
  assign rx_valid = rxv_ff;
endmodule : serial_word_shifter
`default_nettype wire

/* File: rtl/background_debug_control.sv */
// Purpose: Debug mode entry, serial command execution and return
// Assumes: core handshakes on mclk; link pins are asynchronous
// Notes: Pins fall back to pipeline tracking while not frozen
// Notes on behaviour
// RULE1: breakpoint, double fault or background instruction halts core and raises freeze
// RULE2: entry writes source code into scratch register
// RULE3: host reads scratch first; later commands reuse it as storage
// RULE4: double fault straight after reset marks last-instruction pointer with one
// RULE5: command is one opword plus optional 16-bit extension words
// RULE6: words are taken as assembled; command runs once complete
// RULE7: results go to output shifter while next command shifts in
// RULE8: read or write selected data or address register
// RULE9: read or write system control registers
// RULE10: memory read at long address in source space
// RULE11: memory write at long address in destination space
// RULE12: block dump returns next operand after initial read
// RULE13: block fill writes next operand after initial write
// RULE14: resume flushes pipe and restarts at current program counter
// RULE15: patch call pushes program counter at stack pointer then runs patch
// RULE16: peripheral reset drives system reset 512 cycles; no-op does nothing
// RULE17: fault address holds last faulting or last bus cycle address
// RULE18: odd return fetch pointer raises address error on first prefetch
// RULE19: last-instruction pointer holds first word of last executed instruction
// RULE20: only resume or patch call end debug mode, keeping pointer and supervisor bit
// RULE21: freeze drops before first prefetch; pins return to tracking
// RULE22: breakpoint pin is serial clock, fetch pin input, pipe pin output
// RULE23: 17-bit words, MSB first, bit 16 status, host bit ignored
// RULE24: data changes on falling edge, captured on rising edge
// RULE25: host serial clock is at most half the system clock
// RULE26: answers: valid data, complete, not ready, bus error, illegal
// RULE27: fixed operation word encoding shared with the host
`timescale 1ns/1ps
`default_nettype none
module background_debug_control
  import bdm_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Shared pins
  input wire logic breakpoint_in_n,
  input wire logic fetch_track_out_i,
  output logic fetch_track_out_o,
  output logic fetch_track_out_oe_n,
  output logic pipe_advance_out,
  // Core status and events
  input wire logic pipe_advance_core,
  input wire logic fetch_track_core,
  input wire logic bdm_enable,
  input wire logic dbl_fault,
  input wire logic background_instruction_exec,
  input wire logic first_fetch_fault,
  input wire logic [15:0] fault_status_word,
  input wire logic [31:0] last_instr_addr,
  input wire logic [31:0] current_pc,
  input wire logic supervisor_state_bit_in,
  input wire logic bus_cycle_strobe,
  input wire logic [31:0] bus_cycle_addr,
  // Core control
  output logic freeze,
  output logic resume,
  output logic resume_addr_error,
  output logic [31:0] resume_pc,
  output logic supervisor_state_bit_out,
  output logic sys_reset_out,
  // Core register port
  output logic creg_valid,
  output creg_req_t creg,
  input wire logic creg_ack,
  input wire logic [31:0] creg_rdata,
  // Memory port
  output logic mem_valid,
  output mem_req_t mem,
  input wire logic mem_ack,
  input wire logic mem_berr,
  input wire logic [31:0] mem_rdata
);
  typedef enum logic [5:0] {
    S_RUN = 6'h01,
    S_CMD = 6'h02,
    S_CREG = 6'h04,
    S_MEM = 6'h08,
    S_RST = 6'h10,
    S_EXIT = 6'h20
  } state_t;

  function automatic logic [2:0] ext_words(input logic [15:0] w);
    logic [2:0] dw;
    dw = (w[SIZE_LSB +: 2] == SZ_LONG) ? 3'h2 : 3'h1;
    case (w[OP_LSB +: 4])
      OP_CORE_WR, OP_SYS_WR, OP_MEM_RD: ext_words = 3'h2;
      OP_MEM_WR: ext_words = 3'h2 + dw;
      OP_FILL: ext_words = dw;
      default: ext_words = 3'h0;
    endcase
  endfunction : ext_words

  // Packs {answer word, low half pending, low half}
  function automatic logic [33:0] result(input logic [31:0] v, input logic [1:0] sz);
    case (sz)
      SZ_LONG: result = {1'h0, v[31:16], 1'h1, v[15:0]};
      SZ_WORD: result = {1'h0, v[15:0], 1'h0, 16'h0000};
      default: result = {1'h0, 8'h00, v[7:0], 1'h0, 16'h0000};
    endcase
  endfunction : result

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and serial engine
  logic bk_s1_ff, bk_s2_ff, di_s1_ff, di_s2_ff;
  logic sdo;
  logic [15:0] rx_word;
  logic rx_valid;

  always_ff @(posedge mclk) begin
    if (rst) begin
      bk_s1_ff <= 1'h1;
      bk_s2_ff <= 1'h1;
      di_s1_ff <= 1'h0;
      di_s2_ff <= 1'h0;
    end else begin
      bk_s1_ff <= breakpoint_in_n;
      bk_s2_ff <= bk_s1_ff;
      di_s1_ff <= fetch_track_out_i;
      di_s2_ff <= di_s1_ff;
    end
  end

  state_t state_ff, nxt_state;
  logic freeze_ff, nxt_freeze;
  logic [16:0] tx_ff, nxt_tx;

  // Link edges are seen by sampling, so the host clock must stay slow
  serial_word_shifter u_shift ( // RULE22 RULE25
    .mclk(mclk),
    .rst(rst),
    .enable(freeze_ff),
    .sclk_s(bk_s2_ff),
    .sdi_s(di_s2_ff),
    .sdo(sdo),
    .tx_word(tx_ff),
    .rx_word(rx_word),
    .rx_valid(rx_valid)
  );

  ////////////////////////////////////////////////////////////////////////
  // Command engine
  logic [31:0] scratch_ff, nxt_scratch;
  logic [31:0] fault_ff, nxt_fault;
  logic [31:0] rfp_ff, nxt_rfp;
  logic [31:0] lip_ff, nxt_lip;
  logic [2:0] src_ff, nxt_src, dst_ff, nxt_dst;
  logic supervisor_state_bit_ff, nxt_supervisor_state_bit;
  logic [15:0] op_ff, nxt_op;
  logic [2:0] got_ff, nxt_got;
  logic [31:0] addr_ff, nxt_addr;
  logic pend_v_ff, nxt_pend_v;
  logic [15:0] pend_ff, nxt_pend;
  logic [9:0] rcnt_ff, nxt_rcnt;
  logic sysrst_ff, nxt_sysrst;
  logic resume_ff, nxt_resume, aerr_ff, nxt_aerr;
  logic creg_v_ff, nxt_creg_v, mem_v_ff, nxt_mem_v;
  creg_req_t creg_ff, nxt_creg;
  mem_req_t mem_ff, nxt_mem;
  logic go_exec, enter;
  logic [3:0] opc, idx;
  logic [1:0] sz;
  logic [31:0] sysval, step;

  assign enter = bdm_enable && (dbl_fault || background_instruction_exec || !bk_s2_ff);
  assign opc = op_ff[OP_LSB +: 4];
  assign sz = op_ff[SIZE_LSB +: 2];
  assign step = (sz == SZ_LONG) ? 32'h00000004 : (sz == SZ_WORD) ? 32'h00000002 : 32'h00000001;

  always_comb begin
    nxt_state = state_ff;
    nxt_freeze = freeze_ff;
    nxt_tx = tx_ff;
    nxt_scratch = scratch_ff;
    nxt_fault = bus_cycle_strobe ? bus_cycle_addr : fault_ff; // RULE17
    nxt_rfp = rfp_ff;
    nxt_lip = lip_ff;
    nxt_src = src_ff;
    nxt_dst = dst_ff;
    nxt_supervisor_state_bit = supervisor_state_bit_ff;
    nxt_op = op_ff;
    nxt_got = got_ff;
    nxt_addr = addr_ff;
    nxt_pend_v = pend_v_ff;
    nxt_pend = pend_ff;
    nxt_rcnt = rcnt_ff;
    nxt_sysrst = sysrst_ff;
    nxt_resume = 1'h0;
    nxt_aerr = 1'h0;
    nxt_creg_v = creg_v_ff;
    nxt_creg = creg_ff;
    nxt_mem_v = mem_v_ff;
    nxt_mem = mem_ff;
    go_exec = 1'h0;
    idx = 4'h0;
    sysval = REG_RST;
    case (state_ff)
      S_RUN: begin
        if (enter) begin
          nxt_freeze = 1'h1; // RULE1
          nxt_state = S_CMD;
          nxt_got = 3'h0;
          nxt_tx = RSP_NOT_READY;
          nxt_pend_v = 1'h0;
          nxt_supervisor_state_bit = supervisor_state_bit_in;
          nxt_rfp = current_pc;
          if (dbl_fault) begin
            nxt_scratch = {fault_status_word, DBL_FAULT_LOW}; // RULE2
          end else if (background_instruction_exec) begin
            nxt_scratch = ENTRY_BACKGROUND_INSTRUCTION; // RULE2
          end else begin
            nxt_scratch = ENTRY_BREAKPOINT_IN; // RULE2
          end
          // Only the reset-time double fault may leave an odd value
          nxt_lip = (dbl_fault && first_fetch_fault) ? LIP_DBL_RESET : {last_instr_addr[31:1], 1'h0}; // RULE4 RULE19
        end
      end
      S_CMD: begin
        if (rx_valid) begin
          nxt_tx = pend_v_ff ? {1'h0, pend_ff} : RSP_NOT_READY; // RULE7
          nxt_pend_v = 1'h0;
          if (got_ff == 3'h0) begin
            nxt_op = rx_word; // RULE5
            go_exec = ext_words(rx_word) == 3'h0; // RULE6
            nxt_got = go_exec ? 3'h0 : 3'h1;
          end else begin
            // Memory read and write shift their first two extension words into addr_ff; all other extension words park in scratch, so it no longer shows the entry code
            if ((opc == OP_MEM_RD || opc == OP_MEM_WR) && got_ff < 3'h3) begin
              nxt_addr = {addr_ff[15:0], rx_word};
            end else begin
              nxt_scratch = {scratch_ff[15:0], rx_word}; // RULE3
            end
            go_exec = got_ff == ext_words(op_ff); // RULE6
            nxt_got = go_exec ? 3'h0 : got_ff + 3'h1;
          end
        end
      end
      S_CREG: begin
        if (creg_ack) begin
          nxt_creg_v = 1'h0;
          nxt_state = S_CMD;
          if (opc == OP_CALL) begin
            nxt_addr = creg_rdata;
            nxt_mem_v = 1'h1;
            nxt_mem = '{we: 1'h1, space: dst_ff, size: SZ_LONG, addr: creg_rdata, wdata: rfp_ff}; // RULE15
            nxt_state = S_MEM;
          end else if (!creg_ff.we) begin
            {nxt_tx, nxt_pend_v, nxt_pend} = result(creg_rdata, SZ_LONG); // RULE8 RULE9
          end else begin
            nxt_tx = RSP_OK; // RULE26
          end
        end
      end
      S_MEM: begin
        if (mem_ack || mem_berr) begin
          nxt_mem_v = 1'h0;
          nxt_state = S_CMD;
          if (mem_berr) begin
            nxt_tx = RSP_BERR; // RULE26
          end else if (opc == OP_CALL) begin
            nxt_freeze = 1'h0; // RULE20
            nxt_state = S_EXIT;
          end else begin
            nxt_addr = addr_ff + step; // RULE12 RULE13
            if (!mem_ff.we) begin
              {nxt_tx, nxt_pend_v, nxt_pend} = result(mem_rdata, sz); // RULE10 RULE12
            end else begin
              nxt_tx = RSP_OK; // RULE11 RULE13
            end
          end
        end
      end
      S_RST: begin
        nxt_rcnt = rcnt_ff + 10'h001;
        if (rcnt_ff == 10'(RST_CYCLES - 1)) begin
          nxt_sysrst = 1'h0; // RULE16
          nxt_tx = RSP_OK;
          nxt_state = S_CMD;
        end
      end
      S_EXIT: begin
        // Freeze already low here, so prefetch starts one cycle later
        nxt_resume = 1'h1; // RULE14 RULE21
        nxt_aerr = rfp_ff[0]; // RULE18
        nxt_state = S_RUN;
      end
      default: nxt_state = S_RUN;
    endcase

    if (go_exec) begin
      idx = nxt_op[IDX_LSB +: 4];
      case (idx)
        SYS_SCRATCH: sysval = scratch_ff;
        SYS_FAULT: sysval = fault_ff;
        SYS_RFP: sysval = rfp_ff;
        SYS_LIP: sysval = lip_ff;
        SYS_SRC: sysval = {29'h00000000, src_ff};
        SYS_DST: sysval = {29'h00000000, dst_ff};
        default: sysval = {31'h00000000, supervisor_state_bit_ff};
      endcase
      case (nxt_op[OP_LSB +: 4]) // RULE27
        OP_NOP: begin
          if (!pend_v_ff) begin
            nxt_tx = RSP_OK; // RULE16
          end
        end
        OP_CORE_RD, OP_CORE_WR: begin
          nxt_creg_v = 1'h1;
          nxt_creg = '{we: nxt_op[OP_LSB +: 4] == OP_CORE_WR, sys: 1'h0, idx: idx, wdata: nxt_scratch}; // RULE8
          nxt_state = S_CREG;
        end
        OP_SYS_RD, OP_SYS_WR: begin
          if (idx[SYS_CORE_BIT]) begin
            nxt_creg_v = 1'h1;
            nxt_creg = '{we: nxt_op[OP_LSB +: 4] == OP_SYS_WR, sys: 1'h1, idx: idx, wdata: nxt_scratch}; // RULE9
            nxt_state = S_CREG;
          end else if (idx > SYS_SUPERVISOR_STATE_BIT) begin
            nxt_tx = RSP_ILLEGAL; // RULE26
          end else if (nxt_op[OP_LSB +: 4] == OP_SYS_RD) begin
            {nxt_tx, nxt_pend_v, nxt_pend} = result(sysval, SZ_LONG); // RULE9
          end else begin
            nxt_tx = RSP_OK;
            case (idx) // RULE9 RULE20
              SYS_SCRATCH: nxt_scratch = nxt_scratch;
              SYS_RFP: nxt_rfp = nxt_scratch;
              SYS_SRC: nxt_src = nxt_scratch[2:0];
              SYS_DST: nxt_dst = nxt_scratch[2:0];
              SYS_SUPERVISOR_STATE_BIT: nxt_supervisor_state_bit = nxt_scratch[0];
              default: nxt_tx = RSP_OK;
            endcase
          end
        end
        OP_MEM_RD, OP_DUMP: begin
          nxt_mem_v = 1'h1;
          nxt_mem = '{we: 1'h0, space: src_ff, size: nxt_op[SIZE_LSB +: 2], addr: nxt_addr, wdata: REG_RST}; // RULE10 RULE12
          nxt_state = S_MEM;
        end
        OP_MEM_WR, OP_FILL: begin
          nxt_mem_v = 1'h1;
          nxt_mem = '{we: 1'h1, space: dst_ff, size: nxt_op[SIZE_LSB +: 2], addr: nxt_addr, wdata: nxt_scratch}; // RULE11 RULE13
          nxt_state = S_MEM;
        end
        OP_GO: begin
          nxt_freeze = 1'h0; // RULE20 RULE14
          nxt_state = S_EXIT;
        end
        OP_CALL: begin
          nxt_creg_v = 1'h1;
          nxt_creg = '{we: 1'h0, sys: 1'h0, idx: SP_IDX, wdata: REG_RST}; // RULE15
          nxt_state = S_CREG;
        end
        OP_RST: begin
          nxt_sysrst = 1'h1; // RULE16
          nxt_rcnt = 10'h000;
          nxt_state = S_RST;
        end
        default: nxt_tx = RSP_ILLEGAL; // RULE26
      endcase
      if (nxt_state == S_CREG || nxt_state == S_MEM || nxt_state == S_RST) begin
        nxt_tx = RSP_NOT_READY; // RULE26
        nxt_pend_v = 1'h0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_ff <= S_RUN;
      freeze_ff <= 1'h0;
      tx_ff <= RSP_NOT_READY;
      scratch_ff <= REG_RST;
      fault_ff <= REG_RST;
      rfp_ff <= REG_RST;
      lip_ff <= REG_RST;
      src_ff <= SPACE_RST;
      dst_ff <= SPACE_RST;
      supervisor_state_bit_ff <= 1'h1;
      op_ff <= 16'h0000;
      got_ff <= 3'h0;
      addr_ff <= REG_RST;
      pend_v_ff <= 1'h0;
      pend_ff <= 16'h0000;
      rcnt_ff <= 10'h000;
      sysrst_ff <= 1'h0;
      resume_ff <= 1'h0;
      aerr_ff <= 1'h0;
      creg_v_ff <= 1'h0;
      creg_ff <= '0;
      mem_v_ff <= 1'h0;
      mem_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      freeze_ff <= nxt_freeze;
      tx_ff <= nxt_tx;
      scratch_ff <= nxt_scratch;
      fault_ff <= nxt_fault;
      rfp_ff <= nxt_rfp;
      lip_ff <= nxt_lip;
      src_ff <= nxt_src;
      dst_ff <= nxt_dst;
      supervisor_state_bit_ff <= nxt_supervisor_state_bit;
      op_ff <= nxt_op;
      got_ff <= nxt_got;
      addr_ff <= nxt_addr;
      pend_v_ff <= nxt_pend_v;
      pend_ff <= nxt_pend;
      rcnt_ff <= nxt_rcnt;
      sysrst_ff <= nxt_sysrst;
      resume_ff <= nxt_resume;
      aerr_ff <= nxt_aerr;
      creg_v_ff <= nxt_creg_v;
      creg_ff <= nxt_creg;
      mem_v_ff <= nxt_mem_v;
      mem_ff <= nxt_mem;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs and pin sharing
  assign pipe_advance_out = freeze_ff ? sdo : pipe_advance_core; // RULE22 RULE21
  assign fetch_track_out_o = fetch_track_core;
  assign fetch_track_out_oe_n = freeze_ff; // RULE21
  assign freeze = freeze_ff;
  assign resume = resume_ff;
  assign resume_addr_error = aerr_ff;
  assign resume_pc = rfp_ff;
  assign supervisor_state_bit_out = supervisor_state_bit_ff;
  assign sys_reset_out = sysrst_ff;
  assign creg_valid = creg_v_ff;
  assign creg = creg_ff;
  assign mem_valid = mem_v_ff;
  assign mem = mem_ff;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  logic [9:0] rhi_ff;
  always_ff @(posedge mclk) begin
    if (rst) begin
      rhi_ff <= 10'h000;
    end else begin
      rhi_ff <= sysrst_ff ? rhi_ff + 10'h001 : 10'h000;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_entry_freeze: assert property (state_ff == S_RUN && enter |=> freeze_ff && state_ff == S_CMD) // RULE1
    else $error("entry did not freeze");
  a_dbl_code: assert property (state_ff == S_RUN && enter && dbl_fault |=> scratch_ff[15:0] == DBL_FAULT_LOW) // RULE2
    else $error("bad double fault code");
  a_background_instruction_code: assert property (state_ff == S_RUN && enter && !dbl_fault && background_instruction_exec |=> scratch_ff == ENTRY_BACKGROUND_INSTRUCTION) // RULE2
    else $error("bad background code");
  a_lip_even: assert property (state_ff == S_RUN && enter && !(dbl_fault && first_fetch_fault) |=> !lip_ff[0]) // RULE4
    else $error("odd pointer written");
  a_rst_width: assert property ($fell(sysrst_ff) |-> rhi_ff == 10'(RST_CYCLES)) // RULE16
    else $error("reset width wrong");
  a_exit_order: assert property ($fell(freeze_ff) |-> !resume_ff ##1 resume_ff) // RULE21
    else $error("prefetch before freeze drop");
  a_pin_release: assert property (freeze_ff |-> fetch_track_out_oe_n && pipe_advance_out == sdo) // RULE22
    else $error("pins not handed to link");
  a_busy_retry: assert property (state_ff == S_MEM || state_ff == S_CREG |-> tx_ff == RSP_NOT_READY) // RULE26
    else $error("busy answer wrong");
  a_berr_resp: assert property (state_ff == S_MEM && mem_berr |=> tx_ff == RSP_BERR && state_ff == S_CMD) // RULE26
    else $error("bus error answer wrong");
  a_fault_addr: assert property (bus_cycle_strobe |=> fault_ff == $past(bus_cycle_addr)) // RULE17
    else $error("fault address not kept");
  a_odd_resume: assert property (resume_ff |-> resume_addr_error == rfp_ff[0]) // RULE18
    else $error("odd pointer not flagged");

  c_entry: cover property (state_ff == S_RUN && enter);
  c_mem_read: cover property (state_ff == S_MEM && mem_ack && !mem_ff.we);
  c_periph_rst: cover property ($fell(sysrst_ff));
  c_resume: cover property (resume_ff);
endmodule : background_debug_control
`default_nettype wire

/* File: tb/host_link.sv */
// Purpose: Host model that masters the serial debug link
// Assumes: link clock idles high so no breakpoint is seen
// Notes: Released data line shows the inverse of the last bit
`timescale 1ns/1ps
`default_nettype none
module host_link (
  // Link pins
  output logic sclk,
  output logic sdi,
  input wire logic sdo
);
  initial begin
    sclk = 1'b1;
    sdi = 1'b1;
  end
  // One 17-bit full-duplex word, 32 ns bit time
  task automatic xfer(input logic [16:0] tx, output logic [16:0] rx);
    for (int i = 16; i >= 0; i--) begin
      sclk = 1'b0;
      sdi = tx[i];
      #16;
      sclk = 1'b1;
      rx[i] = sdo;
      #16;
    end
    sdi = ~tx[0];
  endtask : xfer
endmodule : host_link
`default_nettype wire

/* File: tb/tb.sv */
// Purpose: Command-level test of the debug controller
// Assumes: host model drives the link pins
// Notes: Core register and memory ports answered here
`timescale 1ns/1ps
`default_nettype none
module tb;
  import bdm_pkg::*;
  logic mclk = 1'b0, rst = 1'b1, background_instruction = 1'b0, dbl = 1'b0, strobe = 1'b0;
  logic creg_ack = 1'b0, mem_ack = 1'b0, mem_berr = 1'b0, seen = 1'b0, rae_s = 1'b0, trk = 1'b1, ffault = 1'b0;
  logic sclk, sdi, sdo, freeze, resume, rae, sysr, creg_valid, mem_valid, oe_n, fto, supervisor_state_bit;
  logic [31:0] baddr = 32'h0, mem_rdata = 32'h0, return_fetch_pointer;
  logic [31:0] ram [256];
  logic [16:0] rx;
  creg_req_t creg;
  mem_req_t mem;
  int errors = 0, checks = 0, cyc = 0, rcnt = 0;
  always #2 mclk = ~mclk;
  host_link i_host (.sclk(sclk), .sdi(sdi), .sdo(sdo));
  background_debug_control i_dut (.mclk(mclk), .rst(rst), .breakpoint_in_n(sclk),
    .fetch_track_out_i(sdi), .fetch_track_out_o(fto), .fetch_track_out_oe_n(oe_n),
    .pipe_advance_out(sdo), .pipe_advance_core(trk), .fetch_track_core(trk),
    .bdm_enable(1'b1), .dbl_fault(dbl), .background_instruction_exec(background_instruction), .first_fetch_fault(ffault),
    .fault_status_word(16'hABCD), .last_instr_addr(32'h00000FFF),
    .current_pc(32'h00001000), .supervisor_state_bit_in(1'b1), .bus_cycle_strobe(strobe),
    .bus_cycle_addr(baddr), .freeze(freeze), .resume(resume), .resume_addr_error(rae),
    .resume_pc(return_fetch_pointer), .supervisor_state_bit_out(supervisor_state_bit), .sys_reset_out(sysr), .creg_valid(creg_valid),
    .creg(creg), .creg_ack(creg_ack), .creg_rdata({28'h1234567, creg.idx}),
    .mem_valid(mem_valid), .mem(mem), .mem_ack(mem_ack), .mem_berr(mem_berr),
    .mem_rdata(mem_rdata));
  ////////////////////////////////////////////////////////////////
  // Core side; top address bit set ends in a bus error
  always @(posedge mclk) begin
    creg_ack <= #1 creg_valid & ~creg_ack;
    mem_ack <= #1 mem_valid & ~mem_ack & ~mem.addr[31];
    mem_berr <= #1 mem_valid & ~mem_berr & mem.addr[31];
    mem_rdata <= #1 ram[mem.addr[7:0]];
    if (mem_valid & mem.we)
      ram[mem.addr[7:0]] <= #1 mem.wdata;
    if (sysr)
      rcnt <= rcnt + 1;
    if (resume) begin
      seen <= 1'b1;
      rae_s <= rae;
    end
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // Host bit 16 always sent clear
  task automatic xw(input logic [15:0] tx, input logic [16:0] e, input bit c);
    i_host.xfer({1'b0, tx}, rx);
    if (c)
      chk("link", {15'h0, e}, {15'h0, rx});
    #100;
  endtask : xw
  task automatic tally_and_finish();
    if (errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge mclk);
    #1 rst = 1'b0;
    strobe = 1'b1;
    baddr = 32'h000000A0;
    @(posedge mclk);
    #1 strobe = 1'b0;
    background_instruction = 1'b1;
    @(posedge mclk);
    #1 background_instruction = 1'b0;
    chk("freeze", 1, freeze);
    chk("oe_n", 1, oe_n);
    xw(16'h3000, RSP_NOT_READY, 1);
    xw(16'h0000, 17'h00000, 1);
    xw(16'h3003, 17'h00001, 1);
    xw(16'h0000, 17'h00000, 1);
    xw(16'h3001, 17'h00FFE, 1);
    xw(16'h0000, 17'h00000, 1);
    xw(16'h1002, 17'h000A0, 1);
    xw(16'h0000, 17'h01234, 1);
    xw(16'h6040, 17'h05672, 1);
    xw(16'h0000, 0, 0);
    xw(16'h0100, 0, 0);
    xw(16'hBEEF, 0, 0);
    xw(16'h8040, RSP_OK, 1);
    xw(16'hCAFE, 0, 0);
    xw(16'h5040, RSP_OK, 1);
    xw(16'h0000, 0, 0);
    xw(16'h0100, 0, 0);
    xw(16'h7040, 17'h0BEEF, 1);
    xw(16'h5040, 17'h0CAFE, 1);
    xw(16'h8000, 0, 0);
    xw(16'h0000, 0, 0);
    xw(16'hB000, RSP_BERR, 1);
    for (int i = 0; i < 600 && sysr !== 1'b0; i++)
      @(posedge mclk);
    #1 chk("reset_len", 512, rcnt);
    xw(16'hF000, RSP_OK, 1);
    xw(16'h4002, RSP_ILLEGAL, 1);
    xw(16'h0000, 0, 0);
    xw(16'h2001, 0, 0);
    xw(16'h9000, RSP_OK, 1);
    chk("resume", 1, seen);
    chk("addr_err", 1, rae_s);
    chk("resume_pc", 32'h00002001, return_fetch_pointer);
    chk("freeze", 0, freeze);
    chk("oe_n", 0, oe_n);
    chk("pipe_out", 1, sdo);
    chk("fetch_out", 1, fto);
    // Second entry: double fault straight out of reset
    dbl = 1'b1;
    ffault = 1'b1;
    @(posedge mclk);
    #1 dbl = 1'b0;
    chk("freeze", 1, freeze);
    xw(16'h3000, RSP_NOT_READY, 1);
    xw(16'h0000, 17'h0ABCD, 1);
    xw(16'h3003, 17'h0FFFF, 1);
    xw(16'h0000, 17'h00000, 1);
    xw(16'h4006, 17'h00001, 1);
    xw(16'h0000, 0, 0);
    xw(16'h0000, 0, 0);
    xw(16'hA000, RSP_OK, 1);
    chk("call_push", 32'h00001000, ram[8'h7F]);
    chk("freeze", 0, freeze);
    chk("supervisor_state_bit", 0, supervisor_state_bit);
    chk("addr_err", 0, rae_s);
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
